// >>> logic/eeg_slave.sv
// Two-wire serial EEPROM slave: 512 bytes with an upper-half write guard.
// Assumes the bench resolves the open-drain data wire and pulls the guard low.
`timescale 1ns/1ps
module eeg_slave
#(
	parameter logic [3:0] DEV_TYPE     = eeg_pkg::DEV_TYPE_DEF,
	parameter int         WRITE_CYCLES = eeg_pkg::WRITE_CYCLES
)(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic scl,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	input  wire logic upper_half_write_guard,
	input  wire logic select_strap_low,
	input  wire logic select_strap_high,
	output logic      prog_busy
);
	import eeg_pkg::*;

	eeg_pins_t  pins_raw;
	eeg_pins_t  pins_s;
	logic       scl_p_q;
	logic       sda_p_q;
	logic       link_bit_q;
	eeg_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic [8:0] addr_q;
	logic       rw_q;
	logic       ack_in_q;
	logic       oe_q;
	logic [7:0] mem_q  [MEM_BYTES];
	logic [7:0] pbuf_q [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pval_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;
	logic       ack_fall;
	logic       end_fall;
	logic       dsel_hit;
	logic       wr_block;
	logic       rd_first;
	logic       rd_next;
	logic       prog_start;
	logic       busy;

	// Link domain: data is sampled on the rising bus clock edge
	always_ff @(posedge scl)
		link_bit_q <= sda_i;

	// Pin levels into mclk; 625 samples per 400 kHz period is ample
	assign pins_raw.scl        = scl;
	assign pins_raw.sda        = sda_i;
	assign pins_raw.guard      = upper_half_write_guard;
	assign pins_raw.strap_high = select_strap_high;
	assign pins_raw.strap_low  = select_strap_low;

	eeg_sync #(.W($bits(eeg_pins_t))) u_sync (
		.mclk (mclk),
		.d    (pins_raw),
		.q    (pins_s)
	);

	// Previous line levels for edge and condition detection
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			scl_p_q <= LINE_IDLE;
			sda_p_q <= LINE_IDLE;
		end
		else
		begin
			scl_p_q <= pins_s.scl;
			sda_p_q <= pins_s.sda;
		end
	end

	// Bus events; link_bit_q is stable for the whole clock period after a rise
	assign scl_rise = pins_s.scl & ~scl_p_q;
	assign scl_fall = ~pins_s.scl & scl_p_q;
	assign start_c  = scl_p_q & pins_s.scl & sda_p_q & ~pins_s.sda;
	assign stop_c   = scl_p_q & pins_s.scl & ~sda_p_q & pins_s.sda;
	assign ack_fall = scl_fall & (cnt_q == ACK_SLOT);
	assign end_fall = scl_fall & (cnt_q == END_SLOT);

	// Select decode: type nibble then strap pair
	assign dsel_hit = (sh_q[7:4] == DEV_TYPE) &&
		(sh_q[3:2] == {pins_s.strap_high, pins_s.strap_low});
	// Only a high guard inhibits, and only in the upper half
	assign wr_block = pins_s.guard & (addr_q >= UPPER_BASE);
	assign rd_first = (state_q == PH_DSEL) & end_fall & rw_q;
	assign rd_next  = (state_q == PH_RDAT) & end_fall & ~ack_in_q;
	assign prog_start = stop_c & (state_q == PH_WDAT) & (|pval_q) & ~busy;

	// Bit slot counter and receive shifter
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt_q    <= '0;
			sh_q     <= '0;
			ack_in_q <= 1'b1;
		end
		else if (start_c || stop_c)
			cnt_q <= '0;
		else if (scl_rise && cnt_q < ACK_SLOT)
		begin
			sh_q  <= {sh_q[6:0], link_bit_q};
			cnt_q <= cnt_q + 4'h1;
		end
		else if (scl_rise && cnt_q == ACK_SLOT)
		begin
			ack_in_q <= link_bit_q;
			cnt_q    <= END_SLOT;
		end
		else if (end_fall)
			cnt_q <= '0;
	end

	// Protocol state and address pointer
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_q <= PH_IDLE;
			addr_q  <= ADDR_RST;
			rw_q    <= 1'b0;
		end
		else if (start_c)
		begin
			// Deaf to the bus while the array programs
			if (!busy)
				state_q <= PH_DSEL;
		end
		else if (stop_c)
			state_q <= PH_IDLE;
		else if (ack_fall)
		begin
			case (state_q)
				PH_DSEL:
					if (!dsel_hit)
						state_q <= PH_SKIP;
					else
					begin
						rw_q      <= sh_q[0];
						addr_q[8] <= sh_q[1];
					end
				PH_ADDR: addr_q[7:0] <= sh_q;
				// Page roll-over stays within the 16-byte page
				PH_WDAT:
					if (!wr_block)
						addr_q[3:0] <= addr_q[3:0] + 4'h1;
				default: ;
			endcase
		end
		else if (end_fall)
		begin
			case (state_q)
				PH_DSEL:
					if (rw_q)
					begin
						state_q <= PH_RDAT;
						addr_q  <= addr_q + 9'h001;
					end
					else
						state_q <= PH_ADDR;
				PH_ADDR: state_q <= PH_WDAT;
				PH_RDAT:
					if (ack_in_q)
						state_q <= PH_SKIP;
					else
						addr_q <= addr_q + 9'h001;
				default: ;
			endcase
		end
	end

	// Open-drain data drive; changes only after a falling clock edge or at a start or stop
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			oe_q <= 1'b0;
			tx_q <= '0;
		end
		else if (start_c || stop_c)
			oe_q <= 1'b0;
		else if (ack_fall)
		begin
			case (state_q)
				PH_DSEL: oe_q <= dsel_hit;
				PH_ADDR: oe_q <= 1'b1;
				PH_WDAT: oe_q <= ~wr_block;
				default: oe_q <= 1'b0;
			endcase
		end
		else if (rd_first || rd_next)
		begin
			tx_q <= mem_q[addr_q];
			oe_q <= ~mem_q[addr_q][7];
		end
		else if (end_fall)
			oe_q <= 1'b0;
		else if (scl_fall && state_q == PH_RDAT && cnt_q != 4'h0 && cnt_q < ACK_SLOT)
		begin
			tx_q <= {tx_q[6:0], 1'b0};
			oe_q <= ~tx_q[6];
		end
	end

	// Page buffer flags; refused bytes leave no trace
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pval_q <= '0;
		else if (ack_fall && state_q == PH_ADDR)
			pval_q <= '0;
		else if (ack_fall && state_q == PH_WDAT && !wr_block)
			pval_q[addr_q[3:0]] <= 1'b1;
	end

	// Page buffer data, no reset needed
	always_ff @(posedge mclk)
	begin
		if (ack_fall && state_q == PH_WDAT && !wr_block)
			pbuf_q[addr_q[3:0]] <= sh_q;
	end

	// Array update at the stop; nonvolatile, so never reset
	always_ff @(posedge mclk)
	begin
		if (prog_start)
			for (int i = 0; i < PAGE_BYTES; i++)
				if (pval_q[i])
					mem_q[{addr_q[8:4], PAGE_W'(i)}] <= pbuf_q[i];
	end

	eeg_prog_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
		.mclk  (mclk),
		.rst_n (rst_n),
		.start (prog_start),
		.busy  (busy)
	);

	// The device only ever pulls the data line low
	assign sda_o     = 1'b0;
	assign sda_oe    = oe_q;
	assign prog_busy = busy;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_busy_no_start:
		assert property (busy && start_c |=> state_q == PH_IDLE)
		else $error("start accepted during programming");
	a_stop_programs:
		assert property (prog_start |=> busy [*8])
		else $error("programming cycle too short");
	a_guard_nack:
		assert property (ack_fall && state_q == PH_WDAT && wr_block
			|=> !oe_q && $stable(pval_q))
		else $error("guarded byte acknowledged or buffered");
	a_data_ack:
		assert property (ack_fall && state_q == PH_WDAT && !wr_block |=> oe_q)
		else $error("data byte not acknowledged");
	a_lower_open:
		assert property (ack_fall && state_q == PH_WDAT && !addr_q[8] |=> oe_q)
		else $error("lower half write refused");
	a_guard_low_open:
		assert property (ack_fall && state_q == PH_WDAT && !pins_s.guard |=> oe_q)
		else $error("write refused with guard low");
	a_select_miss:
		assert property (ack_fall && state_q == PH_DSEL && !dsel_hit
			|=> state_q == PH_SKIP && !oe_q)
		else $error("mismatched select answered");
	a_select_ack:
		assert property (ack_fall && state_q == PH_DSEL && dsel_hit |=> oe_q)
		else $error("matching select not acknowledged");
	a_page_roll:
		assert property (ack_fall && state_q == PH_WDAT && !wr_block
			&& addr_q[3:0] == 4'hf |=> addr_q[3:0] == 4'h0 && $stable(addr_q[8:4]))
		else $error("page address left its page");
	a_read_wrap:
		assert property (rd_next && addr_q == 9'(MEM_BYTES - 1) |=> addr_q == ADDR_RST)
		else $error("read address did not wrap");
	a_seq_read:
		assert property (rd_next |=> state_q == PH_RDAT
			&& addr_q == 9'($past(addr_q) + 9'h001))
		else $error("sequential read did not advance");
	a_drive_low_clk:
		assert property ($rose(oe_q) |-> !pins_s.scl)
		else $error("data driven while clock high");

	c_page_commit: cover property (prog_start && pval_q == '1);
	c_seq_read: cover property (rd_next ##[1:1000] rd_next);
	c_guard_nack: cover property (ack_fall && state_q == PH_WDAT && wr_block);
endmodule : eeg_slave

// >>> common/eeg_pkg.sv
// Shared constants and types for the two-wire EEPROM slave.
// Assumes a 250 MHz system clock; bus pins are resolved outside.
package eeg_pkg;
	// Array geometry
	localparam int MEM_BYTES  = 512;
	localparam int PAGE_BYTES = 16;
	localparam int PAGE_W     = 4;
	localparam logic [8:0] UPPER_BASE = 9'h100; // First guarded address
	localparam logic [8:0] ADDR_RST   = 9'h000;
	// Device type code; arbitrary value
	localparam logic [3:0] DEV_TYPE_DEF = 4'h6;
	// Bit slot counts inside one byte frame
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] END_SLOT = 4'h9;
	localparam logic       LINE_IDLE = 1'b1;
	// Self-timed programming cycle
	localparam int     MCLK_PERIOD_PS = 4000;
	localparam longint WRITE_TIME_NS  = 5000000;
	localparam int     WRITE_CYCLES   =
		int'((WRITE_TIME_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS);

	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_DSEL = 3'h1,
		PH_ADDR = 3'h3,
		PH_WDAT = 3'h2,
		PH_RDAT = 3'h6,
		PH_SKIP = 3'h7
	} eeg_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic guard;
		logic strap_high;
		logic strap_low;
	} eeg_pins_t;
endpackage : eeg_pkg

// >>> logic/eeg_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ps
module eeg_sync
#(
	parameter int W = 5
)(
	input  wire logic         mclk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge mclk)
	begin
		meta_q <= d;
		q      <= meta_q;
	end
endmodule : eeg_sync

// >>> logic/eeg_prog_timer.sv
// Busy timer for the self-timed programming cycle.
// Assumes start is a one-cycle pulse on mclk; starts while busy are dropped.
`timescale 1ns/1ps
module eeg_prog_timer
#(
	parameter int CYCLES = 8
)(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      busy
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_q;

	// Busy stands for exactly CYCLES clocks
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			busy  <= 1'b0;
		end
		else if (start && !busy)
		begin
			cnt_q <= CW'(CYCLES - 1);
			busy  <= 1'b1;
		end
		else if (busy)
		begin
			if (cnt_q == '0)
				busy <= 1'b0;
			else
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule : eeg_prog_timer

// >>> dv/eeg_bus_master.sv
// Behavioural two-wire bus master for the EEPROM slave link.
// Assumes a pull-up outside resolves the open-drain data wire.
`timescale 1ns/1ps
module eeg_bus_master
(
	output logic       scl,
	output logic       sda_pull,
	input  wire logic  sda,
	output logic       res_stb,
	output logic [7:0] res_val
);
	// Link clock stands high outside frames
	initial
	begin
		scl      = 1'b1;
		sda_pull = 1'b0;
		res_stb  = 1'b0;
		res_val  = 8'h00;
	end
	// One 125 ns bit; data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		sda_pull = ~b;
		#31.25 scl = 1'b1;
		#31.25 s = sda;
		#31.25 scl = 1'b0;
		#31.25;
	endtask : bit_io
	// Short strobe so the bench can log each result
	task automatic note(input logic [7:0] v);
		res_val = v;
		res_stb = 1'b1;
		#1 res_stb = 1'b0;
	endtask : note
	task automatic start();
		sda_pull = 1'b0;
		#31.25 scl = 1'b1;
		#31.25 sda_pull = 1'b1;
		#31.25 scl = 1'b0;
		#31.25;
	endtask : start
	task automatic stop();
		sda_pull = 1'b1;
		#31.25 scl = 1'b1;
		#62.5 sda_pull = 1'b0;
		#62.5;
	endtask : stop
	// Byte out MSB first, then the slave's ack slot
	task automatic put(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		note({7'h00, s});
	endtask : put
	// Byte in; the last one is refused to end the read
	task automatic get(input logic last);
		logic       s;
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			bit_io(1'b1, s);
			v = {v[6:0], s};
		end
		note(v);
		bit_io(last, s);
	endtask : get
endmodule : eeg_bus_master

// >>> dv/eeg_slave_test.sv
// Self-checking bench for the two-wire EEPROM slave.
// Assumes the master model above and a pull-up on the data wire.
`timescale 1ns/1ps
module eeg_slave_test;
	import eeg_pkg::*;
	localparam int PROG_CYC = 200;
	logic        mclk, rst_n, guard, st_lo, st_hi, scl, pull;
	logic        sda_o, sda_oe, prog_busy, res_stb, busy_q;
	logic [7:0]  res_val, dev, d0, d1, d2;
	logic [31:0] exp_q[$];
	int          err_total, comparisons, busy_cnt;
	// Open drain: the device's value counts only while it drives
	wire         sda_w = ~pull & (sda_oe ? sda_o : 1'b1); // Pull-up wins when nobody pulls

	eeg_slave #(.DEV_TYPE(DEV_TYPE_DEF), .WRITE_CYCLES(PROG_CYC)) i_dut
	(
		.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .upper_half_write_guard(guard), .select_strap_low(st_lo),
		.select_strap_high(st_hi), .prog_busy(prog_busy)
	);
	eeg_bus_master i_m
	(
		.scl(scl), .sda_pull(pull), .sda(sda_w), .res_stb(res_stb), .res_val(res_val)
	);

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// Results come back in the order they were promised
	always @(posedge res_stb)
		check({24'h0, res_val}, exp_q.size() ? exp_q.pop_front() : 32'hxxxx_xxxx);

	// Length of each programming cycle; sampled mid-cycle, away from the launching edge
	always @(negedge mclk)
	begin
		busy_q   <= prog_busy;
		busy_cnt <= (prog_busy === 1'b1) ? busy_cnt + 1 : 0;
		if (busy_q === 1'b1 && prog_busy === 1'b0)
			check(32'(busy_cnt), exp_q.size() ? exp_q.pop_front() : 32'hxxxx_xxxx);
	end

	task automatic px(input logic [7:0] b, input logic e);
		exp_q.push_back({31'h0, e});
		i_m.put(b);
	endtask : px

	task automatic gx(input logic [7:0] e, input logic last);
		exp_q.push_back({24'h0, e});
		i_m.get(last);
	endtask : gx

	// Busy rises a few cycles after the stop; poll is bounded
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (8) @(negedge mclk);
		while (prog_busy !== 1'b0 && n < 1000)
		begin
			@(negedge mclk);
			n++;
		end
	endtask : wait_idle

	initial
	begin
		rst_n = 1'b0;
		guard = 1'b0;
		{st_hi, st_lo} = 2'($urandom(32'hc907));
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		dev = {DEV_TYPE_DEF, st_hi, st_lo, 2'b00};
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		// Page write at the top of the array, guard low
		i_m.start();
		px(dev | 8'h02, 1'b0);
		px(8'hfe, 1'b0);
		px(d0, 1'b0);
		px(d1, 1'b0);
		exp_q.push_back(32'(PROG_CYC));
		i_m.stop();
		// A start during programming goes unseen
		i_m.start();
		px(dev, 1'b1);
		i_m.stop();
		wait_idle();
		// Single byte at the array base
		i_m.start();
		px(dev, 1'b0);
		px(8'h00, 1'b0);
		px(d2, 1'b0);
		exp_q.push_back(32'(PROG_CYC));
		i_m.stop();
		wait_idle();
		// Guarded upper half: select and address taken, data refused
		@(negedge mclk) guard = 1'b1;
		repeat (4) @(negedge mclk);
		i_m.start();
		px(dev | 8'h02, 1'b0);
		px(8'hfe, 1'b0);
		px(~d0, 1'b1);
		i_m.stop();
		// Straps that do not match
		i_m.start();
		px(dev ^ 8'h0c, 1'b1);
		i_m.stop();
		// Random read running over the end of the array
		i_m.start();
		px(dev | 8'h02, 1'b0);
		px(8'hfe, 1'b0);
		i_m.start();
		px(dev | 8'h03, 1'b0);
		gx(d0, 1'b0);
		gx(d1, 1'b0);
		gx(d2, 1'b1);
		i_m.stop();
		summarize();
	end

	// Watchdog well past the expected run of some 23 us
	initial
	begin
		#100000;
		err_total++;
		summarize();
	end
endmodule : eeg_slave_test
